// [design/lec_regs.vh]
// register map, field positions, reset values and timing for the external control block
`ifndef LEC_REGS_VH
`define LEC_REGS_VH

// byte offsets on the apb bus
`define LEC_OFS_CTRL     12'h000
`define LEC_OFS_RATED    12'h004
`define LEC_OFS_STATUS   12'h008
`define LEC_OFS_SETPT    12'h00c
`define LEC_OFS_RES      12'h010
`define LEC_OFS_SEQ      12'h014

// control register fields
`define LEC_CTRL_RESEN   0
`define LEC_CTRL_INV     1
`define LEC_CTRL_POL     2
`define LEC_CTRL_EXTLD   3
`define LEC_CTRL_SWLD    4
`define LEC_CTRL_MODE_LO 5
`define LEC_CTRL_MODE_HI 6
`define LEC_CTRL_RNG_LO  7
`define LEC_CTRL_RNG_HI  8
`define LEC_CTRL_W       9
`define LEC_CTRL_RST     9'h002

// status register fields
`define LEC_ST_LOAD      0
`define LEC_ST_RNG_LO    1
`define LEC_ST_RNG_HI    2
`define LEC_ST_OVR       3
`define LEC_ST_PAUSE     4
`define LEC_ST_TRIG      5
`define LEC_ST_W         6

// sequence register fields
`define LEC_SEQ_PAUSE    0
`define LEC_SEQ_TRIGCLR  1

// rated value reset
`define LEC_RATED_RST    16'hffff

// range codes
`define LEC_RNG_HIGH     2'h0
`define LEC_RNG_MID      2'h1
`define LEC_RNG_LOW      2'h2

// operating modes
`define LEC_MODE_CC      2'h0
`define LEC_MODE_CR      2'h1
`define LEC_MODE_CV      2'h2
`define LEC_MODE_CP      2'h3

// resistance scale in ohms
`define LEC_RES_FULL_OHM 10000
`define LEC_RES_OVR_OHM  11800

// timing
`define LEC_CLK_PERIOD_NS 10
`define LEC_TRIG_MIN_NS   10000
`define LEC_TRIG_MIN_CYC  ((`LEC_TRIG_MIN_NS + `LEC_CLK_PERIOD_NS - 1) / `LEC_CLK_PERIOD_NS)

`endif

// [design/lec_sync.v]
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module lec_sync #(
    parameter       W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst,
    // pins in, levels out
    input  wire [W-1:0] pinIn,
    output wire [W-1:0] pinOut
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage feeds only the second
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
        end
    end

    assign pinOut = sync_r;

endmodule // lec_sync

// [design/lec_trig_filter.v]
// minimum-width filter for the active-low trigger input
`timescale 1ns/1ps
module lec_trig_filter #(
    parameter CNT_W   = 11,
    parameter MIN_CYC = 1000
) (
    // clock and reset
    input  wire mclk,
    input  wire rst,
    // synchronised trigger level, low active
    input  wire trigN,
    // one pulse per accepted low period
    output reg  trigValid
);

    localparam [CNT_W-1:0] MIN_V = MIN_CYC[CNT_W-1:0];

    reg [CNT_W-1:0] lowCnt_r;

    // count low cycles, fire once on reaching the minimum
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lowCnt_r  <= {CNT_W{1'b0}};
            trigValid <= 1'b0;
        end else if (trigN) begin
            lowCnt_r  <= {CNT_W{1'b0}};   // short pulses die here
            trigValid <= 1'b0;
        end else begin
            trigValid <= (lowCnt_r == MIN_V - 1'b1);
            if (lowCnt_r != MIN_V)
                lowCnt_r <= lowCnt_r + 1'b1;   // saturate, no retrigger
        end
    end

endmodule // lec_trig_filter

// [design/lec_top.v]
// external control connector logic: resistance setpoint, load switch, range and trigger
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "lec_regs.vh"
module lec_top #(
    parameter VAL_W = 16,
    parameter RES_W = 16
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output wire             pready,
    output reg  [31:0]      prdata,
    output wire             pslverr,
    // connector inputs
    input  wire             loadSwitchIn,
    input  wire             rangeSel1In,
    input  wire             rangeSel2In,
    input  wire             trigInN,
    // measured external resistance, ohms
    input  wire [RES_W-1:0] extResOhm,
    // connector outputs
    output reg              loadOnStatus,
    output reg              rangeStat1,
    output reg              rangeStat2,
    // internal control outputs
    output reg  [VAL_W-1:0] setpoint,
    output reg              external_overrange_alarm,
    output reg  [1:0]       activeRange,
    output reg              seqPaused,
    output reg              seqResume
);

    localparam CNT_W = 11;
    localparam integer     RES_FULL_I = `LEC_RES_FULL_OHM;
    localparam integer     RES_OVR_I  = `LEC_RES_OVR_OHM;
    localparam [RES_W-1:0] RES_FULL   = RES_FULL_I[RES_W-1:0];
    localparam [RES_W-1:0] RES_OVR    = RES_OVR_I[RES_W-1:0];
    localparam [VAL_W+RES_W-1:0] DIV_FULL = `LEC_RES_FULL_OHM;

    // software state
    reg  [`LEC_CTRL_W-1:0]  ctrl_r;
    reg  [VAL_W-1:0]        rated_r;
    reg                     trigSeen_r;
    reg                     errFlag_r;

    // synchronised pins
    wire                    loadSw;
    wire                    sel1;
    wire                    sel2;
    wire                    trigN;
    wire                    trigValid;

    // setpoint arithmetic
    reg  [RES_W-1:0]        resClamp;
    reg  [RES_W-1:0]        resEff;
    reg  [VAL_W+RES_W-1:0]  product;
    reg  [VAL_W+RES_W-1:0]  quot;
    reg  [VAL_W-1:0]        setpt_nxt;
    reg                     ovr_nxt;
    reg  [1:0]              range_nxt;

    // apb decode
    wire                    setupPh;
    wire                    accessWr;
    reg                     mapped;
    reg  [31:0]             rdMux;

    // control fields
    wire                    resEn;
    wire                    invSel;
    wire                    load_switch_polarity;
    wire                    extLoadEn;
    wire                    swLoadOn;
    wire [1:0]              opMode;
    wire [1:0]              current_range_setting;

    assign resEn                 = ctrl_r[`LEC_CTRL_RESEN];
    assign invSel                = ctrl_r[`LEC_CTRL_INV];
    assign load_switch_polarity  = ctrl_r[`LEC_CTRL_POL];
    assign extLoadEn             = ctrl_r[`LEC_CTRL_EXTLD];
    assign swLoadOn              = ctrl_r[`LEC_CTRL_SWLD];
    assign opMode                = ctrl_r[`LEC_CTRL_MODE_HI:`LEC_CTRL_MODE_LO];
    assign current_range_setting = ctrl_r[`LEC_CTRL_RNG_HI:`LEC_CTRL_RNG_LO];

    // connector pins idle high (pull-ups), trigger idles high too
    lec_sync #(
        .W       (3),
        .RST_VAL (3'h7)
    ) uPinSync (
        .mclk   (mclk),
        .rst    (rst),
        .pinIn  ({loadSwitchIn, rangeSel2In, rangeSel1In}),
        .pinOut ({loadSw, sel2, sel1})
    );

    // trigger level gets its own stage for clarity
    lec_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) uTrigSync (
        .mclk   (mclk),
        .rst    (rst),
        .pinIn  (trigInN),
        .pinOut (trigN)
    );

    // width filter rejects glitches shorter than the minimum
    lec_trig_filter #(
        .CNT_W   (CNT_W),
        .MIN_CYC (`LEC_TRIG_MIN_CYC)
    ) uTrigFilt (
        .mclk      (mclk),
        .rst       (rst),
        .trigN     (trigN),
        .trigValid (trigValid)
    );

    // apb: zero wait states, read data captured in setup phase
    assign setupPh  = psel & ~penable;
    assign accessWr = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & errFlag_r;

    // address decode and read mux
    always @* begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        case (paddr)
            `LEC_OFS_CTRL: begin
                rdMux[`LEC_CTRL_W-1:0] = ctrl_r;
            end
            `LEC_OFS_RATED: begin
                rdMux[VAL_W-1:0] = rated_r;
            end
            `LEC_OFS_STATUS: begin
                rdMux[`LEC_ST_LOAD]                  = loadOnStatus;
                rdMux[`LEC_ST_RNG_HI:`LEC_ST_RNG_LO] = activeRange;
                rdMux[`LEC_ST_OVR]                   = external_overrange_alarm;
                rdMux[`LEC_ST_PAUSE]                 = seqPaused;
                rdMux[`LEC_ST_TRIG]                  = trigSeen_r;
            end
            `LEC_OFS_SETPT: begin
                rdMux[VAL_W-1:0] = setpoint;
            end
            `LEC_OFS_RES: begin
                rdMux[RES_W-1:0] = extResOhm;
            end
            `LEC_OFS_SEQ: begin
                rdMux[`LEC_SEQ_PAUSE] = seqPaused;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // read data and error flag are latched in setup, stable in access
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata    <= 32'h0000_0000;
            errFlag_r <= 1'b0;
        end else if (setupPh) begin
            prdata    <= rdMux;
            errFlag_r <= ~mapped;
        end
    end

    // writable registers; unmapped writes have no effect
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r  <= `LEC_CTRL_RST;
            rated_r <= `LEC_RATED_RST;
        end else if (accessWr) begin
            if (paddr == `LEC_OFS_CTRL)
                ctrl_r <= pwdata[`LEC_CTRL_W-1:0];
            if (paddr == `LEC_OFS_RATED)
                rated_r <= pwdata[VAL_W-1:0];
        end
    end

    // resistance to setpoint; same scaling in every operating mode
    always @* begin
        if (extResOhm > RES_FULL)
            resClamp = RES_FULL;                       // past full scale holds the end value
        else
            resClamp = extResOhm;
        if (invSel)
            resEff = RES_FULL - resClamp;
        else
            resEff = resClamp;
        // constant divisor, synthesis folds it into a multiply
        product   = rated_r * resEff;
        quot      = product / DIV_FULL;
        setpt_nxt = quot[VAL_W-1:0];                   // quotient never exceeds rated value
        // hysteresis-free band: alarm holds at exactly the limit
        if (extResOhm > RES_OVR)
            ovr_nxt = 1'b1;
        else if (extResOhm < RES_OVR)
            ovr_nxt = 1'b0;
        else
            ovr_nxt = external_overrange_alarm;
        if (!resEn)
            ovr_nxt = 1'b0;
        if (ovr_nxt)
            setpt_nxt = {VAL_W{1'b0}};
    end

    // setpoint and alarm, only driven while resistance control is selected
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            setpoint                 <= {VAL_W{1'b0}};
            external_overrange_alarm <= 1'b0;
        end else begin
            external_overrange_alarm <= ovr_nxt;
            if (resEn)
                setpoint <= setpt_nxt;
            else
                setpoint <= {VAL_W{1'b0}};
        end
    end

    // load switch: closed pulls low, open floats high; polarity picks on-level
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            loadOnStatus <= 1'b0;
        end else if (extLoadEn) begin
            loadOnStatus <= (loadSw == load_switch_polarity);
        end else begin
            loadOnStatus <= swLoadOn;
        end
    end

    // range: pins only count while the panel range is high
    always @* begin
        range_nxt = activeRange;
        if (current_range_setting != `LEC_RNG_HIGH) begin
            range_nxt = current_range_setting;
        end else begin
            case ({sel2, sel1})
                2'h3: range_nxt = `LEC_RNG_HIGH;
                2'h2: range_nxt = `LEC_RNG_MID;
                2'h1: range_nxt = `LEC_RNG_LOW;
                default: range_nxt = activeRange;
            endcase
        end
    end

    // active range and its two status lines
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            activeRange <= `LEC_RNG_HIGH;
            rangeStat1  <= 1'b0;
            rangeStat2  <= 1'b0;
        end else begin
            activeRange <= range_nxt;
            rangeStat1  <= (range_nxt == `LEC_RNG_MID);
            rangeStat2  <= (range_nxt == `LEC_RNG_LOW);
        end
    end

    // sequence pause: software pauses, a valid trigger resumes
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            seqPaused <= 1'b0;
            seqResume <= 1'b0;
        end else begin
            seqResume <= trigValid & seqPaused;
            if (trigValid & seqPaused)
                seqPaused <= 1'b0;
            else if (accessWr && paddr == `LEC_OFS_SEQ && pwdata[`LEC_SEQ_PAUSE])
                seqPaused <= 1'b1;
        end
    end

    // sticky trigger flag; a trigger in the clear cycle wins
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            trigSeen_r <= 1'b0;
        end else if (trigValid) begin
            trigSeen_r <= 1'b1;
        end else if (accessWr && paddr == `LEC_OFS_SEQ && pwdata[`LEC_SEQ_TRIGCLR]) begin
            trigSeen_r <= 1'b0;
        end
    end

    // opMode is informational here: scaling is mode independent
    wire unusedMode = ^opMode;

endmodule // lec_top

// [tb/lec_monitor.sv]
// assertions on the external control connector block
`timescale 1ns/1ps
`include "lec_regs.vh"
module lec_monitor #(
    parameter VAL_W = 16,
    parameter RES_W = 16
) (
    // clock, reset and bus
    input wire             mclk,
    input wire             rst,
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire             pslverr,
    // connector pins
    input wire             loadSwitchIn,
    input wire             rangeSel1In,
    input wire             rangeSel2In,
    input wire             trigInN,
    input wire [RES_W-1:0] extResOhm,
    // results
    input wire             loadOnStatus,
    input wire             rangeStat1,
    input wire             rangeStat2,
    input wire [VAL_W-1:0] setpoint,
    input wire             external_overrange_alarm,
    input wire [1:0]       activeRange,
    input wire             seqPaused,
    input wire             seqResume
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0]  wrHist_r;
    logic [10:0] lowCnt_r;
    logic [10:0] lastLow_r;
    wire         wrNow = psel & penable & pwrite;
    wire         wrAny = wrNow | (|wrHist_r);
    // recent writes and trigger low length; sync delay can let the pin rise before resume shows
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrHist_r <= '0;
            lowCnt_r <= '0;
            lastLow_r <= '0;
        end else begin
            wrHist_r <= {wrHist_r[2:0], wrNow};
            if (!trigInN && lowCnt_r != 11'h7ff) begin
                lowCnt_r <= lowCnt_r + 11'h1;
            end else if (trigInN) begin
                lowCnt_r <= '0;
                if (lowCnt_r != 0) lastLow_r <= lowCnt_r;
            end
        end
    end
    sequence sPulse;
        seqResume ##1 !seqResume;
    endsequence
    resume_cause_a: assert property (seqResume |-> $past(seqPaused) && !seqPaused)
        else $error("resume without pause");
    resume_pulse_a: assert property (seqResume |-> sPulse)
        else $error("resume longer than one cycle");
    trig_width_a: assert property (seqResume |-> lowCnt_r >= 1000 || lastLow_r >= 1000)
        else $error("resume after short trigger");
    load_cause_a: assert property ($changed(loadOnStatus) |-> wrAny || $past(loadSwitchIn) != $past(loadSwitchIn, 4))
        else $error("load state moved without cause");
    range_cause_a: assert property ($changed(activeRange) |->
        wrAny || $past({rangeSel2In, rangeSel1In}) != $past({rangeSel2In, rangeSel1In}, 4))
        else $error("range moved without cause");
    stat_mid_a: assert property (rangeStat1 |-> activeRange == `LEC_RNG_MID || $past(activeRange) == `LEC_RNG_MID)
        else $error("first status without mid range");
    stat_low_a: assert property (rangeStat2 |-> activeRange == `LEC_RNG_LOW || $past(activeRange) == `LEC_RNG_LOW)
        else $error("second status without low range");
    alarm_rise_a: assert property ($rose(external_overrange_alarm) |->
        $past(extResOhm) > `LEC_RES_OVR_OHM || $past(extResOhm, 2) > `LEC_RES_OVR_OHM)
        else $error("alarm without overrange");
    alarm_zero_a: assert property (external_overrange_alarm && $past(external_overrange_alarm) |-> setpoint == 0)
        else $error("setpoint not zero in alarm");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule // lec_monitor
bind lec_top lec_monitor #(.VAL_W(VAL_W), .RES_W(RES_W)) mon_u (.mclk, .rst, .psel, .penable, .pwrite,
    .pslverr, .loadSwitchIn, .rangeSel1In, .rangeSel2In, .trigInN, .extResOhm, .loadOnStatus, .rangeStat1,
    .rangeStat2, .setpoint, .external_overrange_alarm, .activeRange, .seqPaused, .seqResume);

// [tb/lec_pins_model.sv]
// connector side: switches, resistance source and trigger controller
`timescale 1ns/1ps
module lec_pins_model (
    // clock
    input wire         mclk,
    // commands from the bench
    input wire         swClosed,
    input wire         sel1Closed,
    input wire         sel2Closed,
    input wire  [15:0] resOhm,
    // connector pins
    output wire        loadSwitchIn,
    output wire        rangeSel1In,
    output wire        rangeSel2In,
    output logic       trigInN,
    output wire [15:0] extResOhm
);
    // pull-ups: an open contact reads high
    assign loadSwitchIn = !swClosed;
    assign rangeSel1In = !sel1Closed;
    assign rangeSel2In = !sel2Closed;
    assign extResOhm = resOhm;
    initial trigInN = 1'b1;
    // low pulse of n cycles; short ones are deliberate misuse
    task pulse(input int n);
        trigInN <= 1'b0;
        repeat (n) @(posedge mclk);
        trigInN <= 1'b1;
    endtask
endmodule // lec_pins_model

// [tb/lec_tb.sv]
// self-checking bench for the external control block
`timescale 1ns/1ps
`include "lec_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s at %h exp %h got %h", n, paddr, e, g); end end
module tb;
    logic        mclk = 0, rst = 1, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        swClosed, sel1C, sel2C, loadSwitchIn, rangeSel1In, rangeSel2In, trigInN;
    logic [15:0] resOhm, extResOhm, setpoint;
    logic        loadOnStatus, rangeStat1, rangeStat2, alarm, seqPaused, seqResume;
    logic [1:0]  activeRange;
    logic [35:0] expQ[$], mskQ[$], gotV, e, m;
    int          fails = 0, compares = 0, rated, r, rc, sp, alm = 0, resumes = 0;
    logic [1:0]  lv[8] = '{3, 2, 0, 1, 0, 3, 3, 3};
    logic [1:0]  ex[8] = '{0, 1, 1, 2, 2, 0, 1, 2};
    always #5 mclk = ~mclk;
    lec_top dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .loadSwitchIn, .rangeSel1In, .rangeSel2In, .trigInN, .extResOhm, .loadOnStatus, .rangeStat1,
        .rangeStat2, .setpoint, .external_overrange_alarm(alarm), .activeRange, .seqPaused, .seqResume);
    lec_pins_model pm (.mclk, .swClosed, .sel1Closed(sel1C), .sel2Closed(sel2C), .resOhm, .loadSwitchIn,
        .rangeSel1In, .rangeSel2In, .trigInN, .extResOhm);
    task test_done;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer, held until pready is seen at an edge
    task xfer(input [11:0] a, input w, input [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: next call never drives psel twice in one step
        @(posedge mclk);
    endtask
    // pin flags are {slave error, second status, first status, load state}
    task rd(input [11:0] a, input [31:0] ev, input [31:0] mv, input [3:0] pe = 0, input [3:0] pmk = 4'h8);
        expQ.push_back({pe, ev});
        mskQ.push_back({pmk, mv});
        xfer(a, 1'b0, 32'h0);
    endtask
    // checker side: oldest note against each completed read
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            gotV = {pslverr, rangeStat2, rangeStat1, loadOnStatus, prdata};
            e = expQ.pop_front();
            m = mskQ.pop_front();
            `CHK("read", e, gotV & m)
        end
    end
    // resume pulses seen on the output
    always @(posedge mclk) begin
        if (seqResume === 1'b1) resumes++;
    end
    // budget is about ten times the expected run
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, swClosed, sel1C, sel2C, resOhm} = '0;
        void'($urandom(13));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`LEC_OFS_CTRL, 32'h002, 32'hffffffff);
        rd(`LEC_OFS_RATED, 32'hffff, 32'hffffffff);
        rd(`LEC_OFS_STATUS, 32'h0, 32'hffffffff, 4'h0, 4'hf);
        rd(12'h020, 32'h0, 32'hffffffff, 4'h8, 4'h8);
        // polarity against both switch positions
        for (int i = 0; i < 4; i++) begin
            xfer(`LEC_OFS_CTRL, 1'b1, 32'h0a | (i[1] << 2));
            swClosed <= i[0];
            repeat (5) @(posedge mclk);
            rd(`LEC_OFS_STATUS, !i[0] == i[1], 32'h1, {3'h0, !i[0] == i[1]}, 4'h9);
        end
        xfer(`LEC_OFS_CTRL, 1'b1, 32'h12);
        rd(`LEC_OFS_STATUS, 32'h1, 32'h1, 4'h1, 4'h9);
        // pin range table, then panel mid and low
        for (int k = 0; k < 8; k++) begin
            xfer(`LEC_OFS_CTRL, 1'b1, k < 6 ? 32'h002 : (k == 6 ? 32'h082 : 32'h102));
            sel2C <= !lv[k][1];
            sel1C <= !lv[k][0];
            repeat (5) @(posedge mclk);
            rd(`LEC_OFS_STATUS, {29'h0, ex[k], 1'b0}, 32'h6, {1'b0, ex[k] == 2, ex[k] == 1, 1'b0}, 4'he);
        end
        // resistance setpoint, boundaries first, every mode
        for (int k = 0; k < 12; k++) begin
            rated = $urandom & 32'hffff;
            r = k == 0 ? 0 : k == 1 ? 10000 : k == 2 ? 11801 : k == 3 ? 11000 : $urandom_range(12500, 0);
            xfer(`LEC_OFS_RATED, 1'b1, rated);
            xfer(`LEC_OFS_CTRL, 1'b1, 32'h1 | (k[0] << 1) | (k[2:1] << 5));
            resOhm <= r;
            repeat (4) @(posedge mclk);
            rc = r > 10000 ? 10000 : r;
            alm = r > 11800 ? 1 : (r < 11800 ? 0 : alm);
            sp = alm ? 0 : (k[0] ? rated * (10000 - rc) / 10000 : rated * rc / 10000);
            rd(`LEC_OFS_SETPT, sp, 32'hffff);
            rd(`LEC_OFS_STATUS, {28'h0, alm[0], 3'h0}, 32'h8);
            rd(`LEC_OFS_RES, r, 32'hffff);
        end
        // pause, short trigger ignored, long one resumes
        xfer(`LEC_OFS_SEQ, 1'b1, 32'h1);
        rd(`LEC_OFS_STATUS, 32'h10, 32'h30);
        rd(`LEC_OFS_SEQ, 32'h1, 32'h1);
        pm.pulse(500);
        repeat (5) @(posedge mclk);
        rd(`LEC_OFS_STATUS, 32'h10, 32'h30);
        `CHK("short resume", 0, resumes)
        pm.pulse(1010);
        repeat (5) @(posedge mclk);
        rd(`LEC_OFS_STATUS, 32'h20, 32'h30);
        `CHK("long resume", 1, resumes)
        xfer(`LEC_OFS_SEQ, 1'b1, 32'h2);
        rd(`LEC_OFS_STATUS, 32'h0, 32'h30);
        repeat (3) @(posedge mclk);
        `CHK("pending reads", 0, expQ.size())
        test_done();
    end
endmodule // tb
